//--- src/gpcfg_regs.sv
// pin setup registers for pins 27 to 30, AHB-Lite slave
// assumes a single AHB-Lite master and synchronous pin inputs
// What this block does
// - direction bit is the matching port direction bit; 0 input, 1 output
// - input buffer bit 0 connects, 1 disconnects and stops sampling
// - drive 0..3: standard/strong low and high combinations
// - drive 4,5: low not driven, high standard or strong
// - drive 6,7: high not driven, low standard or strong
// - sense field: 0 off, 2 senses high, 3 senses low
`timescale 1ns/100ps
module gpcfg_regs
  import gpcfg_pkg::*;
#(
  parameter int unsigned NPINS = 4
)(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output wire logic [31:0]      hrdata,
  output wire logic             hreadyout,
  output wire logic             hresp,
  input  wire logic [NPINS-1:0] dir_in,
  input  wire logic [NPINS-1:0] port_out_val,
  input  wire logic [NPINS-1:0] pad_in,
  output wire logic [NPINS-1:0] dir_wr_en,
  output wire logic [NPINS-1:0] dir_wr_val,
  output wire logic [NPINS-1:0] pad_oe,
  output wire logic [NPINS-1:0] pad_out,
  output wire logic [NPINS-1:0] pad_strong,
  output wire logic [NPINS-1:0] pad_in_en,
  output wire logic [NPINS-1:0] sampled_in,
  output wire logic [NPINS-1:0] pull_down_en,
  output wire logic [NPINS-1:0] pull_up_en,
  output wire logic [NPINS-1:0] sense_req
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // maps a byte address onto a pin index, returns NPINS when unmapped
  function automatic logic [3:0] pin_index(input logic [31:0] addr);
    logic [31:0] rel;
    rel = addr - {20'h0_0000, GPCFG_PIN27_SETUP_OFS};
    if (addr[1:0] == 2'h0 && addr >= {20'h0_0000, GPCFG_PIN27_SETUP_OFS}
        && rel[31:2] < NPINS)
      pin_index = rel[5:2];
    else
      pin_index = 4'(NPINS);
  endfunction : pin_index

  // address phase capture
  logic       wr_pend_q;
  logic [3:0] wr_idx_q;
  logic [3:0] rd_idx_q;

  wire logic       addr_valid = hsel & htrans[1] & hready;
  wire logic [3:0] ap_idx     = pin_index(haddr);

  // captured address phase for the following data phase
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
      rd_idx_q  <= 4'h0;
    end else begin
      wr_pend_q <= addr_valid & hwrite;
      if (addr_valid) begin
        wr_idx_q <= ap_idx;
        rd_idx_q <= ap_idx;
      end
    end
  end

  // ---------------------------------------------------------------
  // setup registers
  // ---------------------------------------------------------------
  logic [31:0] setup_q [NPINS];
  logic [31:0] rdata_q;
  wire  logic [31:0] read_word [NPINS];

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      wire logic hit = wr_pend_q & (wr_idx_q == 4'(gi));

      // one register per pin, unused bits held at zero
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          setup_q[gi] <= GPCFG_RESET_VAL;
        end else if (hit) begin
          setup_q[gi] <= hwdata & GPCFG_WR_MASK;
        end
      end

      // direction bit aliases the port direction bit
      assign dir_wr_en[gi]  = hit;
      assign dir_wr_val[gi] = hwdata[GPCFG_DIR_BIT];
      assign read_word[gi]  = {setup_q[gi][31:1], dir_in[gi]};

      gpcfg_pin_decode u_dec (
        .setup_word   (read_word[gi]),
        .port_out_val (port_out_val[gi]),
        .pad_in       (pad_in[gi]),
        .pad_oe       (pad_oe[gi]),
        .pad_out      (pad_out[gi]),
        .pad_strong   (pad_strong[gi]),
        .pad_in_en    (pad_in_en[gi]),
        .sampled_in   (sampled_in[gi]),
        .pull_down_en (pull_down_en[gi]),
        .pull_up_en   (pull_up_en[gi]),
        .sense_req    (sense_req[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // unmapped words read zero
  wire logic [31:0] rd_sel = (ap_idx < 4'(NPINS)) ? read_word[ap_idx[1:0]] : 32'h0000_0000;

  // read word registered at the address phase
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_valid & ~hwrite) begin
      rdata_q <= rd_sel;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : gpcfg_regs

//--- src/gpcfg_pkg.sv
// package for the pin setup register block
// assumes a 32-bit word bus with byte addresses
package gpcfg_pkg;

  // register byte addresses
  localparam logic [11:0] GPCFG_PIN27_SETUP_OFS = 12'h076C;
  localparam logic [11:0] GPCFG_PIN28_SETUP_OFS = 12'h0770;
  localparam logic [11:0] GPCFG_PIN29_SETUP_OFS = 12'h0774;
  localparam logic [11:0] GPCFG_PIN30_SETUP_OFS = 12'h0778;
  localparam int unsigned GPCFG_FIRST_PIN       = 27;

  // field positions
  localparam int unsigned GPCFG_DIR_BIT    = 0;
  localparam int unsigned GPCFG_INBUF_BIT  = 1;
  localparam int unsigned GPCFG_PULL_LSB   = 2;
  localparam int unsigned GPCFG_DRIVE_LSB  = 8;
  localparam int unsigned GPCFG_SENSE_LSB  = 16;

  // writable bits and reset value
  localparam logic [31:0] GPCFG_WR_MASK    = 32'h0003_070F;
  localparam logic [31:0] GPCFG_RESET_VAL  = 32'h0000_0002;

  // pull encodings
  localparam logic [1:0] GPCFG_PULL_NONE = 2'h0;
  localparam logic [1:0] GPCFG_PULL_DOWN = 2'h1;
  localparam logic [1:0] GPCFG_PULL_UP   = 2'h3;

  // sense encodings
  localparam logic [1:0] GPCFG_SENSE_OFF  = 2'h0;
  localparam logic [1:0] GPCFG_SENSE_HIGH = 2'h2;
  localparam logic [1:0] GPCFG_SENSE_LOW  = 2'h3;

  // drive strength combinations
  typedef enum logic [2:0] {
    standard_low_standard_high = 3'h0,
    strong_low_standard_high   = 3'h1,
    standard_low_strong_high   = 3'h2,
    strong_low_strong_high     = 3'h3,
    open_low_standard_high     = 3'h4,
    open_low_strong_high       = 3'h5,
    standard_low_open_high     = 3'h6,
    strong_low_open_high       = 3'h7
  } gpcfg_drive_t;

endpackage : gpcfg_pkg

//--- src/gpcfg_pin_decode.sv
// decodes one pin setup register into pad controls
// assumes the register word comes straight from the register file
`timescale 1ns/100ps
module gpcfg_pin_decode
  import gpcfg_pkg::*;
(
  input  wire logic [31:0] setup_word,
  input  wire logic        port_out_val,
  input  wire logic        pad_in,
  output wire logic        pad_oe,
  output wire logic        pad_out,
  output wire logic        pad_strong,
  output wire logic        pad_in_en,
  output wire logic        sampled_in,
  output wire logic        pull_down_en,
  output wire logic        pull_up_en,
  output wire logic        sense_req
);

  // ---------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------
  wire logic       dir_out  = setup_word[GPCFG_DIR_BIT];
  wire logic       buf_off  = setup_word[GPCFG_INBUF_BIT];
  wire logic [1:0] pull_sel = setup_word[GPCFG_PULL_LSB +: 2];
  wire logic [2:0] drv_sel  = setup_word[GPCFG_DRIVE_LSB +: 3];
  wire logic [1:0] sns_sel  = setup_word[GPCFG_SENSE_LSB +: 2];

  // ---------------------------------------------------------------
  // drive decode
  // ---------------------------------------------------------------
  // strength per level
  wire logic low_strong  = (drv_sel == strong_low_standard_high) |
                           (drv_sel == strong_low_strong_high) |
                           (drv_sel == strong_low_open_high);
  wire logic high_strong = (drv_sel == standard_low_strong_high) |
                           (drv_sel == strong_low_strong_high) |
                           (drv_sel == open_low_strong_high);
  wire logic low_open    = (drv_sel == open_low_standard_high) |
                           (drv_sel == open_low_strong_high);
  wire logic high_open   = (drv_sel == standard_low_open_high) |
                           (drv_sel == strong_low_open_high);

  assign pad_out    = port_out_val;
  assign pad_oe     = dir_out & (port_out_val ? ~high_open : ~low_open);
  assign pad_strong = port_out_val ? high_strong : low_strong;

  assign pad_in_en  = ~buf_off;
  assign sampled_in = pad_in & ~buf_off;

  assign pull_down_en = (pull_sel == GPCFG_PULL_DOWN);
  assign pull_up_en   = (pull_sel == GPCFG_PULL_UP);

  // level sense request, raw pin level
  assign sense_req = ((sns_sel == GPCFG_SENSE_HIGH) & pad_in) |
                     ((sns_sel == GPCFG_SENSE_LOW) & ~pad_in);

endmodule : gpcfg_pin_decode

//--- tb/gpcfg_regs_monitor.sv
// checker on the pin setup register ports
// assumes it is bound onto every gpcfg_regs instance
`timescale 1ns/100ps
module gpcfg_regs_monitor
  import gpcfg_pkg::*;
#(
  parameter int unsigned NPINS = 4
)(
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hwdata,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [NPINS-1:0] dir_in,
  input wire logic [NPINS-1:0] dir_wr_en,
  input wire logic [NPINS-1:0] dir_wr_val,
  input wire logic [NPINS-1:0] pad_oe,
  input wire logic [NPINS-1:0] pad_in,
  input wire logic [NPINS-1:0] pad_in_en,
  input wire logic [NPINS-1:0] sampled_in,
  input wire logic [NPINS-1:0] pull_down_en,
  input wire logic [NPINS-1:0] pull_up_en
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // accepted address phases
  wire rd = hsel && htrans[1] && !hwrite && hready;
  wire wr = hsel && htrans[1] && hwrite && hready;
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_DIR_CAUSE: assert property (|dir_wr_en |-> $past(wr))
    else $error("direction load without a write");
  AST_DIR_PULSE: assert property (wr && haddr == 32'h0000_076C |=> dir_wr_en[0])
    else $error("direction load missing");
  AST_DIR_VAL: assert property ((dir_wr_val & dir_wr_en) == ({NPINS{hwdata[0]}} & dir_wr_en))
    else $error("direction value not write bit");
  AST_OE_DIR: assert property ((pad_oe & ~dir_in) == '0)
    else $error("pin driven while input");
  AST_SAMPLE: assert property (sampled_in == (pad_in & pad_in_en))
    else $error("sampled level wrong");
  AST_PULL: assert property ((pull_up_en & pull_down_en) == '0)
    else $error("both pulls on");
  AST_UNMAPPED: assert property (rd && haddr == 32'h0000_077C |=> hrdata == '0)
    else $error("unmapped read not zero");
  AST_RD_MASK: assert property (rd |=> (hrdata & ~GPCFG_WR_MASK) == '0)
    else $error("unused bits not zero");
  COV_DIR: cover property (|dir_wr_en);
  COV_HOLE: cover property (rd && haddr == 32'h0000_077C);
  COV_OE: cover property (|pad_oe);
endmodule : gpcfg_regs_monitor
bind gpcfg_regs gpcfg_regs_monitor #(.NPINS(NPINS)) u_mon (.sys_clk, .reset, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .dir_in, .dir_wr_en,
  .dir_wr_val, .pad_oe, .pad_in, .pad_in_en, .sampled_in, .pull_down_en, .pull_up_en);

//--- tb/gpcfg_board.sv
// board side of the pins
// assumes the bench gives the level the board drives
`timescale 1ns/100ps
module gpcfg_board #(
  parameter int unsigned NPINS = 4
)(
  input  wire logic [NPINS-1:0] pad_oe,
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] ext_val,
  output wire logic [NPINS-1:0] pad_in
);
  // block drive wins, board level otherwise
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : gpcfg_board

//--- tb/gpcfg_regs_tb_top.sv
// bench for the pin setup registers
// assumes one bus master and a board model on the pins
`timescale 1ns/100ps
module gpcfg_regs_tb_top;
  import gpcfg_pkg::*;
  logic        sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, r;
  logic [3:0]  dir_in = 4'h0, port_out_val = 4'h0, ext_val = 4'h0;
  int          failures = 0, check_count = 0;
  wire logic        hready, hresp;
  wire logic [31:0] hrdata;
  wire logic [3:0]  pad_in, pad_oe, pad_out, pad_strong, pad_in_en, sampled_in;
  wire logic [3:0]  pull_down_en, pull_up_en, sense_req, dir_wr_en, dir_wr_val;
  gpcfg_regs uut (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .dir_in, .port_out_val, .pad_in, .dir_wr_en,
    .dir_wr_val, .pad_oe, .pad_out, .pad_strong, .pad_in_en, .sampled_in, .pull_down_en,
    .pull_up_en, .sense_req);
  gpcfg_board board (.pad_oe, .pad_out, .ext_val, .pad_in);
  initial forever #2 sys_clk = ~sys_clk;
  // port direction register loaded by the block
  always @(posedge sys_clk)
    dir_in <= reset ? 4'h0 : (dir_in & ~dir_wr_en) | (dir_wr_val & dir_wr_en);
  // one single transfer, read data left in r
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 32'h0000_076C + 32'(4 * i), 32'h0000_0000);
      chk("reset value", GPCFG_RESET_VAL, r);
    end
    xfer(1'b1, 32'h0000_0770, 32'hFFFF_FFFF);
    xfer(1'b1, 32'h0000_077C, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0000_0770, 32'h0000_0000);
    chk("pin28 mask", GPCFG_WR_MASK, r);
    xfer(1'b0, 32'h0000_077C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, r);
    xfer(1'b0, 32'h0000_0774, 32'h0000_0000);
    chk("pin29 apart", GPCFG_RESET_VAL, r);
  endtask : t_regs
  task automatic t_drive();
    logic oe;
    for (int d = 0; d < 8; d++) begin
      for (int v = 0; v < 2; v++) begin
        xfer(1'b1, 32'h0000_076C, 32'(d) << 8 | 32'h0000_0001);
        port_out_val[0] <= v[0];
        @(posedge sys_clk);
        #1;
        oe = !(v == 0 && d inside {4, 5}) && !(v == 1 && d > 5);
        chk("pad_oe", oe, pad_oe[0]);
        if (oe) begin
          chk("pad_out", v[0], pad_out[0]);
          chk("strong", v ? d inside {2, 3, 5} : d inside {1, 3, 7}, pad_strong[0]);
        end
      end
    end
  endtask : t_drive
  task automatic t_input();
    for (int k = 0; k < 4; k++) begin
      for (int e = 0; e < 2; e++) begin
        ext_val[2] <= e[0];
        xfer(1'b1, 32'h0000_0774, 32'(k) << 16 | 32'(k) << 2 | 32'(k % 2) << 1);
        @(posedge sys_clk);
        #1;
        chk("pull down", k == 1, pull_down_en[2]);
        chk("pull up", k == 3, pull_up_en[2]);
        chk("buffer", k % 2 == 0, pad_in_en[2]);
        chk("sampled", k % 2 == 0 && e == 1, sampled_in[2]);
        chk("sense", (k == 2 && e == 1) || (k == 3 && e == 0), sense_req[2]);
      end
    end
  endtask : t_input
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_drive();
    t_input();
    print_verdict();
  end
  // cut a hang short
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule : gpcfg_regs_tb_top
